// file: pkg/prcc_pkg.sv
package prcc_pkg;
  // ---------------------------------------------------------------------------
  // register map (byte addresses, 32-bit aligned words)
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PRCC_RETRY_TALLY_ADDR   = 32'h0F00_0C30;
  localparam logic [31:0] PRCC_SETUP_CTRL_ADDR    = 32'h0F00_0C34;
  localparam logic [31:0] PRCC_CLK_DIV_SEL_ADDR   = 32'h0F00_0C38;
  // ---------------------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------------------
  localparam int          PRCC_TALLY_W            = 8;
  localparam int          PRCC_SETUP_BIT          = 2;
  localparam int          PRCC_DIV_SEL_W          = 2;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  PRCC_TALLY_RST          = 8'h00;
  localparam logic        PRCC_SETUP_RST          = 1'b0;
  localparam logic [1:0]  PRCC_DIV_SEL_RST        = 2'h0;
  // ---------------------------------------------------------------------------
  // divider codes and half-period counts in internal clock cycles
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  PRCC_SEL_DIV2           = 2'h0;
  localparam logic [1:0]  PRCC_SEL_DIV4           = 2'h1;
  localparam logic [1:0]  PRCC_SEL_DIV1           = 2'h2;
  localparam logic [1:0]  PRCC_SEL_RSVD           = 2'h3;
  localparam logic [1:0]  PRCC_DIV4_HALF_LAST     = 2'h1;
  // ---------------------------------------------------------------------------
  // axi responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  PRCC_RESP_OKAY          = 2'h0;
  localparam logic [1:0]  PRCC_RESP_SLVERR        = 2'h2;
endpackage : prcc_pkg

// file: hw/prcc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// bus clock divider: /1 gives an enable-every-cycle strobe, /2 and /4 toggle
// ---------------------------------------------------------------------------
module prcc_clk_div
  import prcc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // selection
  input  wire logic [1:0] div_sel,
  // divided clock, registered
  output logic            bus_clk,
  output logic            bus_clk_en
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       clk;
    logic       en;
  } prcc_div_state_t;

  prcc_div_state_t st_reg;
  prcc_div_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.en = 1'b0;
    case (div_sel)
      PRCC_SEL_DIV1: begin // [RULE5]
        // divide-by-one cannot come from a flop; the strobe marks every cycle
        st_next.clk = ~st_reg.clk;
        st_next.en  = 1'b1;
        st_next.cnt = 2'h0;
      end
      PRCC_SEL_DIV4: begin // [RULE6]
        if (st_reg.cnt == PRCC_DIV4_HALF_LAST) begin
          st_next.cnt = 2'h0;
          st_next.clk = ~st_reg.clk;
          st_next.en  = ~st_reg.clk;
        end else begin
          st_next.cnt = st_reg.cnt + 2'h1;
        end
      end
      default: begin // [RULE7]
        // reserved code falls back to the reset rate
        st_next.cnt = 2'h0;
        st_next.clk = ~st_reg.clk;
        st_next.en  = ~st_reg.clk;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_clk    = st_reg.clk;
  assign bus_clk_en = st_reg.en;
endmodule : prcc_clk_div
`default_nettype wire

// file: hw/prcc_regs.sv
// Notes on behaviour
// [RULE1] an 8-bit read-only tally of generated retries sits in the low byte of retry_tally.
// [RULE2] software sets the setup-complete bit once the bridge unit is programmed.
// [RULE3] with setup-complete at one, target cycles pass through normally.
// [RULE4] with setup-complete at zero, every target cycle is answered with a retry.
// [RULE5] divider code 10 runs the bus clock at the internal rate; pci_bus_clk_en strobes every cycle, pci_bus_clk runs at half rate.
// [RULE6] divider code 01 divides the internal clock by four.
// [RULE7] divider code 00 divides by two; software does not program code 11.
// [RULE8] reserved bits read as zero and software writes zeros there.
// [RULE9] reset clears the tally, the setup-complete bit and the divider select.
// [RULE10] the tally steps by one on each retry termination issued.
`timescale 1ns/1ps
`default_nettype none
module prcc_regs
  import prcc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pci target side, same clock domain
  input  wire logic        target_cycle_start,
  output logic             target_retry,
  output logic             target_accept,
  // pci bus clock
  output logic             pci_bus_clk,
  output logic             pci_bus_clk_en
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  tally;
    logic        setup_done;
    logic [1:0]  div_sel;
    logic        retry;
    logic        accept;
  } prcc_state_t;

  prcc_state_t st_reg;
  prcc_state_t st_next;
  logic        div_clk;
  logic        div_en;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.retry  = 1'b0;
    st_next.accept = 1'b0;
    // write channels are taken independently, in any order
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = PRCC_RESP_OKAY;
      case (st_reg.aw_addr)
        PRCC_RETRY_TALLY_ADDR: begin
          // read-only; write ignored quietly
        end
        PRCC_SETUP_CTRL_ADDR: begin
          if (st_reg.w_strb[0]) begin
            st_next.setup_done = st_reg.w_data[PRCC_SETUP_BIT]; // [RULE2]
          end
        end
        PRCC_CLK_DIV_SEL_ADDR: begin
          if (st_reg.w_strb[0]) begin
            st_next.div_sel = st_reg.w_data[PRCC_DIV_SEL_W-1:0]; // [RULE7]
          end
        end
        default: begin
          st_next.bresp = PRCC_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // ready flags mirror the holding flags so the ports leave straight from flops
    st_next.awready = !st_next.aw_held;
    st_next.wready  = !st_next.w_held;
    // read: address taken and data presented in the same cycle, arready together with rvalid
    st_next.arready = 1'b0;
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = PRCC_RESP_OKAY;
      st_next.rdata   = 32'h0000_0000; // [RULE8]
      case (s_axi_araddr)
        PRCC_RETRY_TALLY_ADDR: st_next.rdata[PRCC_TALLY_W-1:0] = st_reg.tally; // [RULE1]
        PRCC_SETUP_CTRL_ADDR:  st_next.rdata[PRCC_SETUP_BIT]   = st_reg.setup_done;
        PRCC_CLK_DIV_SEL_ADDR: st_next.rdata[PRCC_DIV_SEL_W-1:0] = st_reg.div_sel;
        default:               st_next.rresp = PRCC_RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // pci target gate
    if (target_cycle_start) begin
      if (st_reg.setup_done) begin
        st_next.accept = 1'b1; // [RULE3]
      end else begin
        st_next.retry = 1'b1; // [RULE4]
        // wraps at 255; a narrow tally is all software sees
        st_next.tally = st_reg.tally + 8'h01; // [RULE10]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg            <= '0;
      st_reg.tally      <= PRCC_TALLY_RST; // [RULE9]
      st_reg.setup_done <= PRCC_SETUP_RST;
      st_reg.div_sel    <= PRCC_DIV_SEL_RST;
      // both write channels stay open while in reset
      st_reg.awready    <= 1'b1;
      st_reg.wready     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // bus clock
  // ---------------------------------------------------------------------------
  prcc_clk_div u_div (
    .clock      (clock),
    .rstn       (rstn),
    .div_sel    (st_reg.div_sel),
    .bus_clk    (div_clk),
    .bus_clk_en (div_en)
  );

  assign s_axi_awready  = st_reg.awready;
  assign s_axi_wready   = st_reg.wready;
  assign s_axi_bvalid   = st_reg.bvalid;
  assign s_axi_bresp    = st_reg.bresp;
  assign s_axi_arready  = st_reg.arready;
  assign s_axi_rvalid   = st_reg.rvalid;
  assign s_axi_rdata    = st_reg.rdata;
  assign s_axi_rresp    = st_reg.rresp;
  assign target_retry   = st_reg.retry;
  assign target_accept  = st_reg.accept;
  assign pci_bus_clk    = div_clk;
  assign pci_bus_clk_en = div_en;
endmodule : prcc_regs
`default_nettype wire

// file: tb/prcc_pci_peer.sv
`timescale 1ns/1ps
`default_nettype none
module prcc_pci_peer (
  // pci master side
  input  wire logic clock,
  input  wire logic target_retry,
  input  wire logic target_accept,
  output logic      target_cycle_start
);
  int retries = 0, accepts = 0;
  initial target_cycle_start = 1'b0;
  always @(posedge clock) begin
    if (target_retry === 1'b1) retries <= retries + 1;
    if (target_accept === 1'b1) accepts <= accepts + 1;
  end
  // gap 0 keeps cycles back to back; a larger gap is a slow master
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      target_cycle_start <= 1'b1;
      if (gap > 0) begin
        @(posedge clock);
        target_cycle_start <= 1'b0;
        repeat (gap - 1) @(posedge clock);
      end
    end
    @(posedge clock);
    target_cycle_start <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : burst
endmodule : prcc_pci_peer
`default_nettype wire

// file: tb/prcc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module prcc_regs_chk (
  // clock, reset, axi handshakes
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // target side, bus clock
  input wire logic        target_cycle_start,
  input wire logic        target_retry,
  input wire logic        target_accept,
  input wire logic        pci_bus_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_rise;
    $rose(pci_bus_clk);
  endsequence
  sequence s_fall;
    $fell(pci_bus_clk);
  endsequence
  AST_TGT_ONE: assert property (target_cycle_start |=> target_retry ^ target_accept)
    else $error("target cycle not answered once");
  AST_TGT_QUIET: assert property (!target_cycle_start |=> !(target_retry || target_accept))
    else $error("answer without target cycle");
  AST_RSVD_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("reserved bits read nonzero");
  AST_R_ANSWER: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready too wide");
  AST_AW_TAKE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  AST_W_TAKE: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data taken twice");
  AST_CLK_HIGH: assert property (s_rise |-> ##[1:2] s_fall)
    else $error("bus clock high too long");
  AST_CLK_LOW: assert property (s_fall |-> ##[1:2] s_rise)
    else $error("bus clock low too long");
endmodule : prcc_regs_chk
bind prcc_regs prcc_regs_chk u_chk (.clock, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .target_cycle_start, .target_retry, .target_accept, .pci_bus_clk);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import prcc_pkg::*;
;
  logic        clock = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        target_cycle_start, target_retry, target_accept, pci_bus_clk, pci_bus_clk_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  always #4 clock = ~clock;
  prcc_regs DUT (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .target_cycle_start, .target_retry, .target_accept, .pci_bus_clk,
    .pci_bus_clk_en);
  prcc_pci_peer peer (.clock, .target_retry, .target_accept, .target_cycle_start);
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                    input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= be;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clock); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clock); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({32'h0, s_axi_bresp}, {32'h0, r});
  endtask : wr
  // rready may lag the request so that the data-hold path is exercised
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] r,
                        input int lag);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    fork
      begin
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
      end
      begin
        if (lag > 0) begin
          repeat (lag) @(posedge clock);
          s_axi_rready <= 1'b1;
        end
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
      end
    join
    s_axi_rready <= 1'b0;
    check({rsp, rd}, {r, exp});
  endtask : rd_chk
  // strobes and clock rises over 16 cycles, phase-independent for /1, /2, /4
  task automatic clk_rate(input int exp_en, input int exp_rise);
    int   n_en;
    int   n_rise;
    logic prev;
    n_en   = 0;
    n_rise = 0;
    prev   = pci_bus_clk;
    repeat (16) begin
      @(posedge clock);
      if (pci_bus_clk_en === 1'b1) n_en++;
      if (pci_bus_clk === 1'b1 && prev === 1'b0) n_rise++;
      prev = pci_bus_clk;
    end
    check(34'(n_en), 34'(exp_en));
    check(34'(n_rise), 34'(exp_rise));
  endtask : clk_rate
  task automatic t_reset;
    rd_chk(PRCC_RETRY_TALLY_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
    rd_chk(PRCC_SETUP_CTRL_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 2);
    rd_chk(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
    rd_chk(PRCC_CLK_DIV_SEL_ADDR + 32'h4, 32'h0, PRCC_RESP_SLVERR, 0);
    clk_rate(8, 8);
  endtask : t_reset
  task automatic t_retry;
    peer.burst(3, 0);
    check(34'(peer.retries), 34'h3);
    check(34'(peer.accepts), 34'h0);
    wr(PRCC_RETRY_TALLY_ADDR, 32'h0000_00A5, 4'hF, PRCC_RESP_OKAY);
    rd_chk(PRCC_RETRY_TALLY_ADDR, 32'h0000_0003, PRCC_RESP_OKAY, 0);
    // 253 more retries carry the tally past 255 back to zero
    peer.burst(253, 0);
    check(34'(peer.retries), 34'h100);
    rd_chk(PRCC_RETRY_TALLY_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
  endtask : t_retry
  task automatic t_setup;
    wr(PRCC_SETUP_CTRL_ADDR, 32'h0000_0004, 4'hE, PRCC_RESP_OKAY);
    rd_chk(PRCC_SETUP_CTRL_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
    wr(PRCC_SETUP_CTRL_ADDR, 32'h0000_0004, 4'hF, PRCC_RESP_OKAY);
    rd_chk(PRCC_SETUP_CTRL_ADDR, 32'h0000_0004, PRCC_RESP_OKAY, 2);
    wr(PRCC_CLK_DIV_SEL_ADDR + 32'h4, 32'h0, 4'hF, PRCC_RESP_SLVERR);
    peer.burst(2, 3);
    check(34'(peer.accepts), 34'h2);
    check(34'(peer.retries), 34'h100);
    rd_chk(PRCC_RETRY_TALLY_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
    wr(PRCC_SETUP_CTRL_ADDR, 32'h0000_0000, 4'hF, PRCC_RESP_OKAY);
    peer.burst(1, 0);
    check(34'(peer.retries), 34'h101);
    rd_chk(PRCC_RETRY_TALLY_ADDR, 32'h0000_0001, PRCC_RESP_OKAY, 0);
  endtask : t_setup
  task automatic t_div;
    wr(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0002, 4'hF, PRCC_RESP_OKAY);
    rd_chk(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0002, PRCC_RESP_OKAY, 0);
    clk_rate(16, 8);
    wr(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0001, 4'hF, PRCC_RESP_OKAY);
    rd_chk(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0001, PRCC_RESP_OKAY, 0);
    clk_rate(4, 4);
    wr(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0002, 4'hE, PRCC_RESP_OKAY);
    clk_rate(4, 4);
    wr(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0000, 4'hF, PRCC_RESP_OKAY);
    rd_chk(PRCC_CLK_DIV_SEL_ADDR, 32'h0000_0000, PRCC_RESP_OKAY, 0);
    clk_rate(8, 8);
  endtask : t_div
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_retry;
    t_setup;
    t_div;
    tally_and_finish;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
endmodule : tb_top
`default_nettype wire
